// [irq_map_pkg.sv]
// line numbers, group sizes and reset values of the interrupt source map
package irq_map_pkg;
  // total numbered lines carried by this map
  localparam int LINE_COUNT = 120;
  // group sizes
  localparam int IPC_COUNT = 8;
  localparam int FAULT_COUNT = 4;
  localparam int MCWDT_COUNT = 2;
  localparam int SERIAL_ACT_COUNT = 7;
  localparam int STD_PORT_COUNT = 23;
  localparam int CTI_COUNT = 2;
  localparam int CAN_CTRL_COUNT = 2;
  localparam int CAN_INT_COUNT = 2;
  localparam int CAN_CH_COUNT = 4;
  localparam int CAN_CH_BITS = 16;
  localparam int LIN_COUNT = 12;
  localparam int CXPI_COUNT = 4;
  localparam int ADC0_COUNT = 24;
  localparam int SUPPLY_COUNT = 3;
  // line positions
  localparam int LINE_IPC_BASE = 0;
  localparam int LINE_FAULT_BASE = 8;
  localparam int LINE_BACKUP = 12;
  localparam int LINE_MCWDT_BASE = 13;
  localparam int LINE_HW_WDT = 15;
  localparam int LINE_SYSRES = 16;
  localparam int LINE_SERIAL0 = 17;
  localparam int LINE_EVT_SLEEP = 18;
  localparam int LINE_SUPPLY = 19;
  localparam int LINE_ALL_PORTS = 20;
  localparam int LINE_ENH_PORT0 = 21;
  localparam int LINE_STD_PORT_BASE = 22;
  localparam int LINE_WAKE_LAST = 44;
  localparam int LINE_CRYPTO = 45;
  localparam int LINE_FLASH = 46;
  localparam int LINE_FPU_FAULT = 47;
  localparam int LINE_CTI_SEC_BASE = 48;
  localparam int LINE_CTI_MAIN_BASE = 50;
  localparam int LINE_EVT_ACTIVE = 52;
  localparam int LINE_CAN_COMB_BASE = 53;
  localparam int LINE_CAN_CH_BASE = 57;
  localparam int LINE_LIN_BASE = 73;
  localparam int LINE_CXPI_BASE = 85;
  localparam int LINE_SERIAL_ACT_BASE = 89;
  localparam int LINE_ADC0_BASE = 96;
  // reset values
  localparam logic [LINE_COUNT-1:0] LINES_RESET = '0;
  localparam logic WAKE_RESET = 1'h0;
  localparam logic [SUPPLY_COUNT-1:0] SUPPLY_RESET = '0;
endpackage

// [supply_mon_if.sv]
// carrier between the map top and the supply change monitor
`timescale 1ns/1ps
`default_nettype none
interface supply_mon_if;
  logic [irq_map_pkg::SUPPLY_COUNT-1:0] level_raw;
  logic ack;
  logic pending;
  modport monitor (input level_raw, input ack, output pending);
  modport user (output level_raw, output ack, input pending);
endinterface
`default_nettype wire

// [supply_change_monitor.sv]
// supply monitor change detector with a sticky pending flag
`timescale 1ns/1ps
`default_nettype none
module supply_change_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  supply_mon_if.monitor mon
);
  typedef struct packed {
    logic [irq_map_pkg::SUPPLY_COUNT-1:0] sync1;
    logic [irq_map_pkg::SUPPLY_COUNT-1:0] sync2;
    logic [irq_map_pkg::SUPPLY_COUNT-1:0] last;
    logic [2:0] primed;
    logic pending;
  } mon_state_t;

  mon_state_t s_r;
  mon_state_t s_nxt;
  logic change;

  // compare only once sync2 and last both hold real samples, so release never looks like a change
  always_comb begin
    s_nxt = s_r;
    change = s_r.primed[2] && (s_r.sync2 != s_r.last);
    if (ce_in) begin
      s_nxt.sync1 = mon.level_raw;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.last = s_r.sync2;
      s_nxt.primed = {s_r.primed[1:0], 1'h1};
      // a change in the ack cycle keeps the flag set
      s_nxt.pending = change || (s_r.pending && !mon.ack);
    end
  end

  // single state register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '{sync1: irq_map_pkg::SUPPLY_RESET, sync2: irq_map_pkg::SUPPLY_RESET,
               last: irq_map_pkg::SUPPLY_RESET, primed: 3'h0, pending: 1'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mon.pending = s_r.pending;

  a_change_sets_pending: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (ce_in && change) |=> s_r.pending) else $error("supply change did not set pending");
  a_pending_holds_level: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_r.pending && !(ce_in && mon.ack)) |=> s_r.pending) else $error("pending dropped without ack");
endmodule
`default_nettype wire

// [interrupt_wakeup_source_map.sv]
// interrupt source to numbered line map with deep sleep wake request
`timescale 1ns/1ps
`default_nettype none
module interrupt_wakeup_source_map (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [irq_map_pkg::IPC_COUNT-1:0] ipc_irq_in,
  input wire logic [irq_map_pkg::FAULT_COUNT-1:0] fault_struct_irq_in,
  input wire logic backup_domain_irq_in,
  input wire logic [irq_map_pkg::MCWDT_COUNT-1:0] multi_watchdog_irq_in,
  input wire logic hw_watchdog_irq_in,
  input wire logic low_voltage_detector_irq_in,
  input wire logic clock_cal_irq_in,
  input wire logic serial0_irq_in,
  input wire logic [irq_map_pkg::SERIAL_ACT_COUNT-1:0] serial_active_irq_in,
  input wire logic event_gen_sleep_irq_in,
  input wire logic event_gen_active_irq_in,
  input wire logic [irq_map_pkg::SUPPLY_COUNT-1:0] supply_monitor_in,
  input wire logic supply_change_ack_in,
  input wire logic enhanced_io_port_irq_in,
  input wire logic [irq_map_pkg::STD_PORT_COUNT-1:0] standard_io_port_irq_in,
  input wire logic crypto_accel_irq_in,
  input wire logic flash_macro_irq_in,
  input wire logic main_core_fpu_fault_irq_in,
  input wire logic [irq_map_pkg::CTI_COUNT-1:0] secondary_core_cti_irq_in,
  input wire logic [irq_map_pkg::CTI_COUNT-1:0] main_core_cti_irq_in,
  input wire logic [irq_map_pkg::CAN_CH_BITS-1:0] can_channel_irq_in,
  input wire logic [irq_map_pkg::LIN_COUNT-1:0] lin_channel_irq_in,
  input wire logic [irq_map_pkg::CXPI_COUNT-1:0] cxpi_channel_irq_in,
  input wire logic [irq_map_pkg::ADC0_COUNT-1:0] adc0_logical_irq_in,
  input wire logic deep_sleep_state_in,
  output logic [irq_map_pkg::LINE_COUNT-1:0] irq_line_out,
  output logic wake_req_out
);
  typedef struct packed {
    logic [irq_map_pkg::LINE_COUNT-1:0] lines;
    logic wake;
  } map_state_t;

  map_state_t s_r;
  map_state_t s_nxt;
  logic supply_pending;

  supply_mon_if mon_bus ();

  // OR of one controller's channel requests for one interrupt number
  function automatic logic can_combined(input logic [irq_map_pkg::CAN_CH_BITS-1:0] ch, input int ctrl,
                                        input int num);
    int base;
    base = (ctrl * irq_map_pkg::CAN_INT_COUNT + num) * irq_map_pkg::CAN_CH_COUNT;
    return |ch[base +: irq_map_pkg::CAN_CH_COUNT];
  endfunction

  // wake request from the deep sleep capable slice of the line vector only
  function automatic logic wake_any(input logic [irq_map_pkg::LINE_COUNT-1:0] lines, input logic asleep);
    return asleep && (|lines[irq_map_pkg::LINE_WAKE_LAST:0]);
  endfunction

  // supply monitors are analog levels, so the sub block synchronises them
  assign mon_bus.level_raw = supply_monitor_in;
  assign mon_bus.ack = supply_change_ack_in;
  assign supply_pending = mon_bus.pending;

  supply_change_monitor u_supply_mon (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .mon(mon_bus.monitor)
  );

  // next line vector; every source but the supply monitors is a same-clock level, passed straight through
  always_comb begin
    s_nxt = s_r;
    if (ce_in) begin
      // deep sleep capable block
      s_nxt.lines[irq_map_pkg::LINE_IPC_BASE +: irq_map_pkg::IPC_COUNT] = ipc_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_FAULT_BASE +: irq_map_pkg::FAULT_COUNT] = fault_struct_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_BACKUP] = backup_domain_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_MCWDT_BASE +: irq_map_pkg::MCWDT_COUNT] = multi_watchdog_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_HW_WDT] = hw_watchdog_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_SYSRES] = low_voltage_detector_irq_in || clock_cal_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_SERIAL0] = serial0_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_EVT_SLEEP] = event_gen_sleep_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_SUPPLY] = supply_pending;
      s_nxt.lines[irq_map_pkg::LINE_ALL_PORTS] = enhanced_io_port_irq_in || (|standard_io_port_irq_in);
      s_nxt.lines[irq_map_pkg::LINE_ENH_PORT0] = enhanced_io_port_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_STD_PORT_BASE +: irq_map_pkg::STD_PORT_COUNT] = standard_io_port_irq_in;
      // active only block
      s_nxt.lines[irq_map_pkg::LINE_CRYPTO] = crypto_accel_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_FLASH] = flash_macro_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_FPU_FAULT] = main_core_fpu_fault_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_CTI_SEC_BASE +: irq_map_pkg::CTI_COUNT] = secondary_core_cti_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_CTI_MAIN_BASE +: irq_map_pkg::CTI_COUNT] = main_core_cti_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_EVT_ACTIVE] = event_gen_active_irq_in;
      // combined can lines, controller 0 first, interrupt 0 before 1
      for (int c = 0; c < irq_map_pkg::CAN_CTRL_COUNT; c++) begin
        for (int n = 0; n < irq_map_pkg::CAN_INT_COUNT; n++) begin
          s_nxt.lines[irq_map_pkg::LINE_CAN_COMB_BASE + c * irq_map_pkg::CAN_INT_COUNT + n] =
            can_combined(can_channel_irq_in, c, n);
        end
      end
      // channel input is already packed controller, interrupt, channel
      s_nxt.lines[irq_map_pkg::LINE_CAN_CH_BASE +: irq_map_pkg::CAN_CH_BITS] = can_channel_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_LIN_BASE +: irq_map_pkg::LIN_COUNT] = lin_channel_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_CXPI_BASE +: irq_map_pkg::CXPI_COUNT] = cxpi_channel_irq_in;
      s_nxt.lines[irq_map_pkg::LINE_SERIAL_ACT_BASE +: irq_map_pkg::SERIAL_ACT_COUNT] = serial_active_irq_in;
      // channels 0..22 and 23 share one contiguous run
      s_nxt.lines[irq_map_pkg::LINE_ADC0_BASE +: irq_map_pkg::ADC0_COUNT] = adc0_logical_irq_in;
      // wake looks at the next lines so it lines up with them on the outputs
      s_nxt.wake = wake_any(s_nxt.lines, deep_sleep_state_in);
    end
  end

  // single state register; ce low freezes everything, lines included
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '{lines: irq_map_pkg::LINES_RESET, wake: irq_map_pkg::WAKE_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign irq_line_out = s_r.lines;
  assign wake_req_out = s_r.wake;

  // checks on the map and the wake path
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_ipc_lines_map: assert property (ce_in |=> irq_line_out[7:0] == $past(ipc_irq_in))
    else $error("ipc lines do not follow ipc requests");
  a_fault_lines_map: assert property (ce_in |=> irq_line_out[11:8] == $past(fault_struct_irq_in))
    else $error("fault lines do not follow fault requests");
  a_backup_watchdog_map: assert property (ce_in |=>
    irq_line_out[12] == $past(backup_domain_irq_in) && irq_line_out[14:13] == $past(multi_watchdog_irq_in))
    else $error("backup or multi watchdog line wrong");
  a_hw_watchdog_map: assert property (ce_in |=> irq_line_out[15] == $past(hw_watchdog_irq_in))
    else $error("hardware watchdog line wrong");
  a_sysres_or_merge: assert property (ce_in && !low_voltage_detector_irq_in && clock_cal_irq_in
    |=> irq_line_out[16]) else $error("calibration request missing on combined line");
  a_sysres_idle_low: assert property (ce_in && !low_voltage_detector_irq_in && !clock_cal_irq_in
    |=> !irq_line_out[16]) else $error("combined line high with no source");
  a_serial_lines_map: assert property (ce_in |=>
    irq_line_out[17] == $past(serial0_irq_in) && irq_line_out[95:89] == $past(serial_active_irq_in))
    else $error("serial lines wrong");
  a_event_gen_map: assert property (ce_in |=>
    irq_line_out[18] == $past(event_gen_sleep_irq_in) && irq_line_out[52] == $past(event_gen_active_irq_in))
    else $error("event generator lines wrong");
  a_supply_line_follow: assert property (ce_in |=> irq_line_out[19] == $past(supply_pending))
    else $error("supply line does not follow pending flag");
  a_all_ports_or: assert property (ce_in && (|standard_io_port_irq_in) |=> irq_line_out[20])
    else $error("combined port line missed a standard port");
  a_port_lines_map: assert property (ce_in |=>
    irq_line_out[21] == $past(enhanced_io_port_irq_in) && irq_line_out[44:22] == $past(standard_io_port_irq_in))
    else $error("port lines wrong");
  a_core_lines_map: assert property (ce_in |=>
    irq_line_out[47:45] == {$past(main_core_fpu_fault_irq_in), $past(flash_macro_irq_in), $past(crypto_accel_irq_in)})
    else $error("crypto flash or fpu line wrong");
  a_cti_lines_map: assert property (ce_in |=>
    irq_line_out[49:48] == $past(secondary_core_cti_irq_in) && irq_line_out[51:50] == $past(main_core_cti_irq_in))
    else $error("cross trigger lines wrong");
  a_can_combined_order: assert property (ce_in |=> irq_line_out[53] == $past(can_combined(can_channel_irq_in, 0, 0))
    && irq_line_out[56] == $past(can_combined(can_channel_irq_in, 1, 1)))
    else $error("combined can line order wrong");
  a_can_channel_map: assert property (ce_in |=> irq_line_out[72:57] == $past(can_channel_irq_in))
    else $error("per channel can lines wrong");
  a_lin_cxpi_map: assert property (ce_in |=>
    irq_line_out[84:73] == $past(lin_channel_irq_in) && irq_line_out[88:85] == $past(cxpi_channel_irq_in))
    else $error("lin or cxpi lines wrong");
  a_adc_low_channels: assert property (ce_in |=> irq_line_out[118:96] == $past(adc0_logical_irq_in[22:0]))
    else $error("adc channels 0 to 22 wrong");
  a_adc_channel_last: assert property (ce_in |=> irq_line_out[119] == $past(adc0_logical_irq_in[23]))
    else $error("adc channel 23 wrong");
  a_line_level_hold: assert property ((ce_in && $stable(lin_channel_irq_in)) [*3] |=>
    $stable(irq_line_out[84:73])) else $error("line moved while its source held steady");
  a_freeze_without_ce: assert property (!ce_in |=> $stable(irq_line_out) && $stable(wake_req_out))
    else $error("state moved with clock enable low");
  a_wake_from_sleep: assert property (ce_in |=>
    wake_req_out == ($past(deep_sleep_state_in) && (|irq_line_out[44:0])))
    else $error("wake request does not match deep sleep lines");
  a_active_lines_no_wake: assert property (ce_in && (|crypto_accel_irq_in) && !wake_any(s_nxt.lines, 1'h1)
    |=> !wake_req_out) else $error("active only line raised wake");

  c_wake_in_sleep: cover property (ce_in && deep_sleep_state_in && hw_watchdog_irq_in ##1 wake_req_out);
  c_can_combined_hit: cover property (ce_in && can_channel_irq_in[15] ##1 irq_line_out[56]);
  c_supply_change: cover property (irq_line_out[19] ##1 ce_in && supply_change_ack_in ##1 !irq_line_out[19]);
  c_active_in_sleep: cover property (ce_in && deep_sleep_state_in && adc0_logical_irq_in[23]
    && !(|irq_line_out[44:0]) ##1 irq_line_out[119] && !wake_req_out);
endmodule
`default_nettype wire

// [irq_ctrl_model.sv]
// stand-in for the core interrupt controllers: latches lines, counts wake requests
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic [irq_map_pkg::LINE_COUNT-1:0] lines_in,
  input wire logic wake_in,
  output logic [irq_map_pkg::LINE_COUNT-1:0] taken_out,
  output logic [7:0] wake_rises_out
);
  logic wake_prev_r;

  // sticky capture, so a one-cycle line is never lost by the bench
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      taken_out <= '0;
      wake_rises_out <= 8'h00;
      wake_prev_r <= 1'b0;
    end else begin
      wake_prev_r <= wake_in;
      if (clr_in) begin
        taken_out <= '0;
        wake_rises_out <= 8'h00;
      end else begin
        taken_out <= taken_out | lines_in;
        if (wake_in && !wake_prev_r) begin
          wake_rises_out <= wake_rises_out + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [interrupt_wakeup_source_map_tb.sv]
// self-checking bench for the interrupt source map and its wake request
`timescale 1ns/1ps
`default_nettype none
module interrupt_wakeup_source_map_tb;
  localparam int NL = irq_map_pkg::LINE_COUNT;
  logic sys_clk, rst_n, ce, deep_sleep, ack, lvdet, cal, backup, hwwdt, ser0, evs, eva, enh, crypto, flash, fpu, clr;
  logic [7:0] ipc;
  logic [3:0] fault;
  logic [1:0] mcwdt, sec_cti, main_cti;
  logic [6:0] ser_act;
  logic [2:0] supply;
  logic [22:0] std_port;
  logic [15:0] can;
  logic [11:0] lin;
  logic [3:0] cxpi;
  logic [23:0] adc;
  logic [NL-1:0] lines, taken;
  logic wake;
  logic [7:0] wake_rises;
  int bad_count = 0;
  int total_checks = 0;

  interrupt_wakeup_source_map dut_u (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .ce_in(ce), .ipc_irq_in(ipc),
    .fault_struct_irq_in(fault), .backup_domain_irq_in(backup), .multi_watchdog_irq_in(mcwdt),
    .hw_watchdog_irq_in(hwwdt), .low_voltage_detector_irq_in(lvdet), .clock_cal_irq_in(cal),
    .serial0_irq_in(ser0), .serial_active_irq_in(ser_act), .event_gen_sleep_irq_in(evs),
    .event_gen_active_irq_in(eva), .supply_monitor_in(supply), .supply_change_ack_in(ack),
    .enhanced_io_port_irq_in(enh), .standard_io_port_irq_in(std_port), .crypto_accel_irq_in(crypto),
    .flash_macro_irq_in(flash), .main_core_fpu_fault_irq_in(fpu), .secondary_core_cti_irq_in(sec_cti),
    .main_core_cti_irq_in(main_cti), .can_channel_irq_in(can), .lin_channel_irq_in(lin),
    .cxpi_channel_irq_in(cxpi), .adc0_logical_irq_in(adc), .deep_sleep_state_in(deep_sleep),
    .irq_line_out(lines), .wake_req_out(wake));

  irq_ctrl_model model_u (.clk_in(sys_clk), .rst_n_in(rst_n), .clr_in(clr), .lines_in(lines), .wake_in(wake),
    .taken_out(taken), .wake_rises_out(wake_rises));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // inputs move 1 ns after the edge so the sampling edge never races them
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // drive the source that belongs on line n; 16 uses the detector half of the OR
  task automatic put(input int n, input logic v);
    if (n < 8) ipc[n] = v;
    else if (n < 12) fault[n-8] = v;
    else if (n == 12) backup = v;
    else if (n < 15) mcwdt[n-13] = v;
    else if (n == 15) hwwdt = v;
    else if (n == 16) lvdet = v;
    else if (n == 17) ser0 = v;
    else if (n == 18) evs = v;
    else if (n == 21) enh = v;
    else if (n < 45) std_port[n-22] = v;
    else if (n == 45) crypto = v;
    else if (n == 46) flash = v;
    else if (n == 47) fpu = v;
    else if (n < 50) sec_cti[n-48] = v;
    else if (n < 52) main_cti[n-50] = v;
    else if (n == 52) eva = v;
    else if (n < 73) can[n-57] = v;
    else if (n < 85) lin[n-73] = v;
    else if (n < 89) cxpi[n-85] = v;
    else if (n < 96) ser_act[n-89] = v;
    else adc[n-96] = v;
  endtask

  // every directly driven line alone, in deep sleep, with its combined lines alongside
  task automatic scen_map();
    logic [NL-1:0] e;
    deep_sleep = 1'b1;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    for (int n = 0; n < NL; n++) begin
      if (n == 19 || n == 20 || (n >= 53 && n <= 56)) continue;
      e = '0;
      e[n] = 1'b1;
      if (n >= 21 && n <= 44) e[20] = 1'b1;
      if (n >= 57 && n <= 72) e[53+(n-57)/4] = 1'b1;
      put(n, 1'b1);
      step(1);
      check(128'(lines), 128'(e));
      check(128'(wake), 128'(n <= 44));
      put(n, 1'b0);
      step(1);
      check(128'(lines), 128'h0);
    end
    e = '1;
    e[19] = 1'b0;
    check(128'(taken), 128'(e));
    check(128'(wake_rises), 128'h2B);
  endtask

  // calibration half of line 16, then the detector half alone
  task automatic scen_sysres();
    cal = 1'b1;
    step(1);
    check(128'(lines[16]), 128'h1);
    lvdet = 1'b1;
    cal = 1'b0;
    step(2);
    check(128'(lines[16]), 128'h1);
    lvdet = 1'b0;
    step(1);
    check(128'(lines[16]), 128'h0);
  endtask

  // each of the three monitors changes in turn; line 19 rises, then is acknowledged away
  task automatic scen_supply();
    for (int b = 0; b < 3; b++) begin
      supply[b] = ~supply[b];
      step(3);
      check(128'(lines[19]), 128'h0);
      step(1);
      check(128'(lines[19]), 128'h1);
      check(128'(wake), 128'h1);
      ack = 1'b1;
      step(1);
      ack = 1'b0;
      check(128'(lines[19]), 128'h1);
      step(1);
      check(128'(lines[19]), 128'h0);
    end
  endtask

  // clock enable low freezes; out of deep sleep a wake-capable line does not wake
  task automatic scen_freeze();
    deep_sleep = 1'b0;
    lin[0] = 1'b1;
    hwwdt = 1'b1;
    ce = 1'b0;
    step(3);
    check(128'(lines), 128'h0);
    ce = 1'b1;
    step(4);
    check(128'(lines[73]), 128'h1);
    check(128'(lines[15]), 128'h1);
    check(128'(wake), 128'h0);
    lin[0] = 1'b0;
    hwwdt = 1'b0;
    step(1);
  endtask

  // reset in mid-run clears lines; a held source returns at the first edge after release
  task automatic scen_reset();
    deep_sleep = 1'b1;
    ipc[0] = 1'b1;
    step(1);
    rst_n = 1'b0;
    #1;
    check(128'(lines), 128'h0);
    check(128'(wake), 128'h0);
    step(1);
    rst_n = 1'b1;
    step(1);
    check(128'(lines[0]), 128'h1);
    check(128'(wake), 128'h1);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // the tests need well under 1000 cycles
  initial begin
    #(40 * 5000);
    bad_count++;
    summarize();
  end

  initial begin
    {ce, deep_sleep, ack, lvdet, cal, backup, hwwdt, ser0, evs, eva, enh, crypto, flash, fpu, clr} = '0;
    {ipc, fault, mcwdt, sec_cti, main_cti, ser_act, supply, std_port, can, lin, cxpi, adc} = '0;
    rst_n = 1'b0;
    ce = 1'b1;
    step(4);
    rst_n = 1'b1;
    step(2);
    scen_map();
    scen_sysres();
    scen_supply();
    scen_freeze();
    scen_reset();
    summarize();
  end
endmodule
`default_nettype wire
